// file: hw/adc_ctl_pkg.sv
// shared constants and carriers for the converter control block
// assumes one 100 MHz clock domain
package adc_ctl_pkg;
  localparam int  CLK_PERIOD_NS   = 10;
  // converter busy time, a least time
  localparam int  CONV_TIME_NS    = 8000;
  localparam int  CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  FIFO_DEPTH      = 1024;
  localparam int  BLOCK_WORDS     = 512;
  localparam int  SAMPLE_W        = 16;
  localparam int  CHAN_W          = 4;
  localparam int  GAIN_W          = 3;
  localparam int  DIV_W           = 16;
  localparam int  COUNT_W         = 16;
  localparam logic [1:0] SRC_OFF  = 2'h0;
  localparam logic [1:0] SRC_A    = 2'h1;
  localparam logic [1:0] SRC_B    = 2'h2;
  localparam logic [2:0] GAIN_MAX = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } conv_state_e;

  typedef struct packed {
    logic [1:0]        first_sel;
    logic [1:0]        second_sel;
    logic              scan_en;
    logic [CHAN_W-1:0] last_channel_select;
    logic [GAIN_W-1:0] gain;
  } acq_cfg_s;

  typedef struct packed {
    logic                first_interrupt_line;
    logic                second_interrupt_line;
    logic                fifo_half_full_transfer;
    logic                overrun;
    logic                data_ready;
    logic                acq_running;
  } acq_stat_s;
endpackage

// file: hw/adc_fifo_interrupt_control.sv
// converter control: triggers, pacer, scan, sample fifo, interrupt status
// assumes converter result arrives on ADC_RESULT at end of busy time
//
// Operation
// - an interrupt status stays set after raising until the host clears it.
// - each of the two interrupt lines has a readable one-bit status.
// - a fifo half-full indication can be sampled at any time.
// - a completely full fifo is flagged as overrun.
// - a software trigger performs one conversion of 12 or 16 bits.
// - paced mode starts conversions from two cascaded pacer dividers.
// - scanning walks channels 0 up to the last channel and wraps to 0.
// - one fixed bipolar range from five settings applies to every channel.
// - paced acquisition runs until the requested count or a host stop.
// - source selects encode 0 off, 1 and 2 as the two sources per line.
// - a zero in either pacer divider stops pacer triggers.
// - a fifo reset discards all stored samples.
`timescale 1ns/1ps
module adc_fifo_interrupt_control
  import adc_ctl_pkg::*;
#(
  parameter int DEPTH    = FIFO_DEPTH,
  parameter int RES_BITS = 12,
  parameter int CONV_CYC = CONV_CYCLES
) (
  input  wire logic                REF_CLK,
  input  wire logic                RESET,
  input  wire acq_cfg_s            CFG,
  input  wire logic [DIV_W-1:0]    PACER_DIVIDER_FIRST,
  input  wire logic [DIV_W-1:0]    PACER_DIVIDER_SECOND,
  input  wire logic [COUNT_W-1:0]  ACQ_COUNT,
  input  wire logic                ACQ_START,
  input  wire logic                ACQ_STOP,
  input  wire logic                SOFT_TRIGGER,
  input  wire logic                RESULT_READ,
  input  wire logic                FIFO_READ,
  input  wire logic                FIFO_RESET,
  input  wire logic                CLEAR_IRQ,
  input  wire logic                EXT_IRQ_PIN,
  input  wire logic [SAMPLE_W-1:0] ADC_RESULT,
  output logic                     ADC_START,
  output logic [CHAN_W-1:0]        ADC_CHANNEL,
  output logic [GAIN_W-1:0]        ADC_GAIN,
  output logic [SAMPLE_W-1:0]      RESULT_DATA,
  output logic [SAMPLE_W-1:0]      FIFO_DATA,
  output logic [COUNT_W-1:0]       DONE_COUNT,
  output acq_stat_s                STATUS
);
  localparam int AW = $clog2(DEPTH);

  logic [SAMPLE_W-1:0] mem [DEPTH];
  logic [AW-1:0]       wr_ptr_ff, rd_ptr_ff;
  logic [AW:0]         level_ff;
  conv_state_e         state_ff;
  logic [15:0]         busy_ff;
  logic                paced_conv_ff, running_ff, first_evt, second_evt;
  logic                ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff;
  logic                irq_first_ff, irq_second_ff, half_full_ff, overrun_ff;
  logic                data_ready_ff, running_q_ff;
  logic                tick1, pacer_tick;
  logic                fifo_full, fifo_wr, fifo_rd, conv_end;
  logic [SAMPLE_W-1:0] masked;

  // status word gathered from flops, each owned by one process
  assign STATUS = '{first_interrupt_line:    irq_first_ff,
                    second_interrupt_line:   irq_second_ff,
                    fifo_half_full_transfer: half_full_ff,
                    overrun:                 overrun_ff,
                    data_ready:              data_ready_ff,
                    acq_running:             running_q_ff};

  //////////////////////////////////////////////////////////////////
  // pacer cascade, stage one counts clocks
  // pacer stop on zero
  // zero divisor halts
  pacer_divider #(.W(DIV_W)) u_div1 (
    .clk      (REF_CLK),
    .rst      (RESET),
    .run      (running_ff),
    .tick_in  (1'b1),
    .divisor  (PACER_DIVIDER_FIRST),
    .tick_out (tick1)
  );
  pacer_divider #(.W(DIV_W)) u_div2 (
    .clk      (REF_CLK),
    .rst      (RESET),
    .run      (running_ff),
    .tick_in  (tick1),
    .divisor  (PACER_DIVIDER_SECOND),
    .tick_out (pacer_tick)
  );

  //////////////////////////////////////////////////////////////////
  // acquisition run control
  // count or stop ends run
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      running_ff <= 1'b0;
      DONE_COUNT <= '0;
    end else if (ACQ_STOP) begin
      running_ff <= 1'b0;
    end else if (ACQ_START) begin
      running_ff <= (ACQ_COUNT != '0);
      DONE_COUNT <= '0;
    end else if (conv_end && paced_conv_ff) begin
      DONE_COUNT <= DONE_COUNT + COUNT_W'(1);
      if (DONE_COUNT + COUNT_W'(1) >= ACQ_COUNT) begin
        running_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // conversion sequencer; triggers arriving while busy are dropped
  assign conv_end = (state_ff == ST_CONV) && (busy_ff == 16'h0000);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff      <= ST_IDLE;
      busy_ff       <= '0;
      paced_conv_ff <= 1'b0;
      ADC_START     <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      case (state_ff)
        ST_IDLE, ST_DONE: begin
          if ((pacer_tick && running_ff) || SOFT_TRIGGER) begin
            state_ff      <= ST_CONV;
            busy_ff       <= 16'(CONV_CYC - 1);
            paced_conv_ff <= pacer_tick && running_ff;
            ADC_START     <= 1'b1;
          end
        end
        ST_CONV: begin
          if (busy_ff == 16'h0000) begin
            state_ff <= ST_DONE;
          end else begin
            busy_ff <= busy_ff - 16'h0001;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // channel scan and range
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ADC_CHANNEL <= '0;
      ADC_GAIN    <= '0;
    end else begin
      ADC_GAIN <= (CFG.gain > GAIN_MAX) ? GAIN_MAX : CFG.gain;
      if (!CFG.scan_en) begin
        ADC_CHANNEL <= CFG.last_channel_select;
      end else if (ACQ_START) begin
        ADC_CHANNEL <= '0;
      end else if (conv_end) begin
        ADC_CHANNEL <= (ADC_CHANNEL >= CFG.last_channel_select) ?
                       '0 : ADC_CHANNEL + CHAN_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // result capture; narrow variant keeps low bits only
  always_comb begin
    for (int i = 0; i < SAMPLE_W; i++) begin
      masked[i] = ADC_RESULT[i] & (i < RES_BITS);
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      RESULT_DATA   <= '0;
      data_ready_ff <= 1'b0;
    end else if (conv_end && !paced_conv_ff) begin
      RESULT_DATA   <= masked;
      data_ready_ff <= 1'b1;
    end else if (RESULT_READ) begin
      data_ready_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////
  // sample fifo; paced samples only
  assign fifo_full = (level_ff == (AW+1)'(DEPTH));
  assign fifo_wr   = conv_end && paced_conv_ff && !fifo_full;
  assign fifo_rd   = FIFO_READ && (level_ff != '0);

  always_ff @(posedge REF_CLK) begin
    if (fifo_wr) begin
      mem[wr_ptr_ff] <= masked;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
      FIFO_DATA <= '0;
    end else if (FIFO_RESET) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
    end else begin
      if (fifo_wr) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (fifo_rd) begin
        FIFO_DATA <= mem[rd_ptr_ff];
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      level_ff <= level_ff + (AW+1)'(fifo_wr) - (AW+1)'(fifo_rd);
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      half_full_ff <= 1'b0;
      overrun_ff   <= 1'b0;
    end else begin
      half_full_ff <= (level_ff >= (AW+1)'(DEPTH / 2));
      // full means overrun; sticky until fifo reset
      if (FIFO_RESET) begin
        overrun_ff <= 1'b0;
      end else if (fifo_full) begin
        overrun_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // external source, three-stage sync with agreement
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      ext_s3_ff  <= 1'b0;
      ext_lvl_ff <= 1'b0;
    end else begin
      ext_s1_ff <= EXT_IRQ_PIN;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      // a change counts only once the last two stages agree
      if (ext_s2_ff == ext_s3_ff) begin
        ext_lvl_ff <= ext_s3_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // interrupt request status; set beats clear
  always_comb begin
    first_evt  = 1'b0;
    second_evt = 1'b0;
    case (CFG.first_sel)
      SRC_A:   first_evt = conv_end && paced_conv_ff;
      // fires on the write that brings the level up to half
      SRC_B:   first_evt = fifo_wr && !fifo_rd &&
                           (level_ff == (AW+1)'(DEPTH / 2 - 1));
      default: first_evt = 1'b0;
    endcase
    case (CFG.second_sel)
      SRC_A:   second_evt = pacer_tick && running_ff;
      SRC_B:   second_evt = ext_s2_ff && ext_s3_ff && !ext_lvl_ff;
      default: second_evt = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      running_q_ff <= 1'b0;
    end else begin
      running_q_ff <= running_ff;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq_first_ff  <= 1'b0;
      irq_second_ff <= 1'b0;
    end else begin
      if (first_evt) begin
        irq_first_ff <= 1'b1;
      end else if (CLEAR_IRQ) begin
        irq_first_ff <= 1'b0;
      end
      if (second_evt) begin
        irq_second_ff <= 1'b1;
      end else if (CLEAR_IRQ) begin
        irq_second_ff <= 1'b0;
      end
    end
  end
endmodule

// file: hw/pacer_divider.sv
// one cascade stage of the pacer: divides an enable pulse train
// assumes the count is stable while running; zero stops output
`timescale 1ns/1ps
module pacer_divider
  import adc_ctl_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] divisor,
  output logic              tick_out
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff   <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (!run || divisor == '0) begin
        cnt_ff <= '0;
      end else if (tick_in) begin
        if (cnt_ff >= divisor - W'(1)) begin
          cnt_ff   <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + W'(1);
        end
      end
    end
  end
endmodule

// file: tb/adc_converter_model.sv
// converter stand-in: one tagged result per start pulse
// assumes a busy time well under the hold count
`timescale 1ns/1ps
module adc_converter_model
  import adc_ctl_pkg::*;
#(
  parameter int HOLD = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic [CHAN_W-1:0] channel,
  output logic [SAMPLE_W-1:0]    result
);
  logic [SAMPLE_W-1:0] hold_ff;
  logic [7:0]          seq_ff;
  logic [3:0]          left_ff;
  // top nibble set so the narrow mask is exercised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff <= 16'h0000;
      seq_ff  <= 8'h00;
      left_ff <= 4'h0;
    end else if (start) begin
      hold_ff <= {4'hF, channel, seq_ff};
      seq_ff  <= seq_ff + 8'h01;
      left_ff <= 4'(HOLD);
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end
  end
  // past the hold time the lines no longer carry the sample
  assign result = (left_ff != 4'h0) ? hold_ff : ~hold_ff;
endmodule

// file: tb/adc_fifo_interrupt_control_properties.sv
// port-level checks of the converter control block
// assumes a conversion time of 4 cycles in simulation
`timescale 1ns/1ps
module adc_fifo_interrupt_control_properties
  import adc_ctl_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              RESET,
  input wire acq_cfg_s          CFG,
  input wire logic [DIV_W-1:0]  PACER_DIVIDER_FIRST,
  input wire logic              SOFT_TRIGGER,
  input wire logic              RESULT_READ,
  input wire logic              FIFO_RESET,
  input wire logic              CLEAR_IRQ,
  input wire logic              ADC_START,
  input wire logic [CHAN_W-1:0] ADC_CHANNEL,
  input wire logic [GAIN_W-1:0] ADC_GAIN,
  input wire acq_stat_s         STATUS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_irq1_hold;
    STATUS.first_interrupt_line && !CLEAR_IRQ |=> STATUS.first_interrupt_line;
  endproperty
  a_irq1_hold: assert property (p_irq1_hold) else $error("irq one dropped");
  property p_irq2_hold;
    STATUS.second_interrupt_line && !CLEAR_IRQ |=> STATUS.second_interrupt_line;
  endproperty
  a_irq2_hold: assert property (p_irq2_hold) else $error("irq two dropped");
  property p_start_gap;
    ADC_START |=> !ADC_START [*3];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("start in busy");
  property p_ready_late;
    ADC_START |=> !$rose(STATUS.data_ready) [*3];
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready early");
  property p_ready_soon;
    ADC_START && !STATUS.acq_running |-> ##[1:8] STATUS.data_ready;
  endproperty
  a_ready_soon: assert property (p_ready_soon) else $error("ready missing");
  property p_ready_clear;
    RESULT_READ |=> !STATUS.data_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready kept");
  property p_ovr_hold;
    STATUS.overrun && !FIFO_RESET |=> STATUS.overrun;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
  property p_fifo_rst;
    FIFO_RESET |-> ##2 !STATUS.overrun && !STATUS.fifo_half_full_transfer;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo not reset");
  property p_fixed_ch;
    ADC_START && !CFG.scan_en |-> ##[0:1] ADC_CHANNEL == CFG.last_channel_select;
  endproperty
  a_fixed_ch: assert property (p_fixed_ch) else $error("wrong channel");
  property p_zero_div;
    // a tick already in the two-stage cascade may still land, so look two back
    PACER_DIVIDER_FIRST == 16'h0000 && $past(PACER_DIVIDER_FIRST) == 16'h0000 &&
      $past(PACER_DIVIDER_FIRST, 2) == 16'h0000 && !SOFT_TRIGGER
      |=> !ADC_START;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("pacer not stopped");
  property p_gain;
    ADC_GAIN <= GAIN_MAX;
  endproperty
  a_gain: assert property (p_gain) else $error("gain out of range");
  c_ovr: cover property (STATUS.overrun);
  c_clr: cover property (STATUS.second_interrupt_line && CLEAR_IRQ);
  c_scan: cover property (ADC_START && CFG.scan_en);
endmodule
bind adc_fifo_interrupt_control adc_fifo_interrupt_control_properties u_props (
  .REF_CLK(REF_CLK), .RESET(RESET), .CFG(CFG), .PACER_DIVIDER_FIRST(PACER_DIVIDER_FIRST),
  .SOFT_TRIGGER(SOFT_TRIGGER), .RESULT_READ(RESULT_READ), .FIFO_RESET(FIFO_RESET),
  .CLEAR_IRQ(CLEAR_IRQ), .ADC_START(ADC_START), .ADC_CHANNEL(ADC_CHANNEL),
  .ADC_GAIN(ADC_GAIN), .STATUS(STATUS));

// file: tb/test_adc_fifo_interrupt_control.sv
// directed bench: soft trigger, paced scan with overflow, irq lines
// assumes a short fifo and a 4-cycle conversion
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_adc_fifo_interrupt_control;
  import adc_ctl_pkg::*;
  localparam int DEPTH = 8;
  localparam int HALF  = DEPTH / 2;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  acq_cfg_s            cfg;
  logic [DIV_W-1:0]    div1;
  logic [DIV_W-1:0]    div2;
  logic [COUNT_W-1:0]  count;
  // start, stop, soft, read, pop, fifo reset, clear
  logic [6:0]          strobe;
  logic                ext;
  logic [SAMPLE_W-1:0] adc_result;
  logic                adc_start;
  logic [CHAN_W-1:0]   adc_channel;
  logic [GAIN_W-1:0]   adc_gain;
  logic [SAMPLE_W-1:0] result_data;
  logic [SAMPLE_W-1:0] fifo_data;
  logic [COUNT_W-1:0]  done_count;
  acq_stat_s           stat;
  int                  fails = 0;
  int                  checks = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////
  adc_fifo_interrupt_control #(.DEPTH(DEPTH), .RES_BITS(12), .CONV_CYC(4))
    u_adc_fifo_interrupt_control (
    .REF_CLK(clk), .RESET(reset), .CFG(cfg), .PACER_DIVIDER_FIRST(div1),
    .PACER_DIVIDER_SECOND(div2), .ACQ_COUNT(count), .ACQ_START(strobe[0]),
    .ACQ_STOP(strobe[1]), .SOFT_TRIGGER(strobe[2]), .RESULT_READ(strobe[3]),
    .FIFO_READ(strobe[4]), .FIFO_RESET(strobe[5]), .CLEAR_IRQ(strobe[6]),
    .EXT_IRQ_PIN(ext), .ADC_RESULT(adc_result), .ADC_START(adc_start),
    .ADC_CHANNEL(adc_channel), .ADC_GAIN(adc_gain), .RESULT_DATA(result_data),
    .FIFO_DATA(fifo_data), .DONE_COUNT(done_count), .STATUS(stat));
  adc_converter_model u_adc_converter_model (
    .clk(clk), .rst(reset), .start(adc_start), .channel(adc_channel),
    .result(adc_result));
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    strobe[i] <= 1'b1;
    @(posedge clk);
    strobe <= 7'h00;
  endtask
  task automatic wait_for(input int what, input logic val);
    int n;
    n = 0;
    while (stat[what] !== val && n < 400) begin
      tick(1);
      n++;
    end
    if (stat[what] !== val) begin
      fails++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    cfg = '0;
    div1 = 16'h0003;
    div2 = 16'h0004;
    count = 16'h0000;
    strobe = 7'h00;
    ext = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    tick(1);
    `CHK(stat, 6'h00)
    cfg.last_channel_select <= 4'h3;
    pulse(2);
    wait_for(1, 1'b1);
    `CHK(result_data, 16'h0300)
    pulse(3);
    tick(1);
    `CHK(stat.data_ready, 1'b0)
    cfg <= '{first_sel: SRC_B, second_sel: SRC_A, scan_en: 1'b1,
             last_channel_select: 4'h2, gain: 3'h7};
    count <= 16'(DEPTH + 1);
    pulse(5);
    pulse(0);
    tick(2);
    `CHK(adc_gain, GAIN_MAX)
    wait_for(0, 1'b0);
    `CHK(done_count, 16'(DEPTH + 1))
    `CHK(stat, 6'h3C)
    for (int k = 0; k < DEPTH; k++) begin
      pulse(4);
      tick(1);
      `CHK(fifo_data, {4'h0, 4'(k % 3), 8'(k + 1)})
      `CHK(stat.fifo_half_full_transfer, logic'(DEPTH - 1 - k >= HALF))
    end
    `CHK(stat.overrun, 1'b1)
    pulse(5);
    tick(2);
    `CHK(stat.overrun, 1'b0)
    pulse(6);
    tick(1);
    `CHK(stat[5:4], 2'b00)
    cfg.first_sel <= SRC_A;
    cfg.second_sel <= SRC_B;
    count <= 16'h0001;
    pulse(0);
    tick(2);
    wait_for(0, 1'b0);
    `CHK(stat[5:4], 2'b10)
    ext <= 1'b1;
    tick(8);
    `CHK(stat[5:4], 2'b11)
    pulse(6);
    tick(1);
    `CHK(stat[5:4], 2'b00)
    div1 <= 16'h0000;
    count <= 16'h0003;
    pulse(0);
    tick(40);
    `CHK(done_count, 16'h0000)
    `CHK(stat.acq_running, 1'b1)
    pulse(1);
    tick(1);
    `CHK(stat.acq_running, 1'b0)
    give_verdict();
  end
endmodule
